// ---- rtl/afec_top.sv ----
// APB register bank holding the analog front end enable bits
//
// Decided for this implementation: register access over APB.
module afec_top (
	// Clock, reset and enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog block controls
	output afec_pkg::afec_enables_t enables,
	output logic [31:0] power_mode
);

	afec_pkg::afec_apb_req_t req;
	logic access;
	logic [1:0] hit;
	logic wr_fe;
	logic wr_pm;
	logic [31:0] fe_value;
	logic [31:0] pm_value;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pslverr_r;
	logic pslverr_nxt;

	// Address decode used by writes and reads
	function automatic logic [1:0] afec_decode(input logic [15:0] addr);
		afec_decode = {addr == afec_pkg::PM_CONFIG_ADDR, addr == afec_pkg::FE_CONFIG_ADDR};
	endfunction

	// Request bundle and access phase
	assign req = '{psel, penable, pwrite, paddr, pwdata};
	assign access = req.psel && req.penable && clk_en;
	assign hit = afec_decode(req.paddr);
	assign wr_fe = access && req.pwrite && hit[0];
	assign wr_pm = access && req.pwrite && hit[1];

	// Front end configuration register
	afec_reg32 #(
		.RESET_VAL(afec_pkg::FE_CONFIG_RESET),
		.WMASK(afec_pkg::FE_CONFIG_WMASK)
	) u_fe_config (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.wr_en(wr_fe),
		.wr_data(req.pwdata),
		.value(fe_value)
	);

	// Power mode configuration register
	afec_reg32 #(
		.RESET_VAL(afec_pkg::PM_CONFIG_RESET),
		.WMASK(32'hffff_ffff)
	) u_pm_config (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.wr_en(wr_pm),
		.wr_data(req.pwdata),
		.value(pm_value)
	);

	// Read data and error, captured in the setup cycle
	always_comb begin
		prdata_nxt = prdata_r;
		pslverr_nxt = pslverr_r;
		if (req.psel && !req.penable) begin
			pslverr_nxt = 1'b0;
			unique case (hit)
				2'b01: prdata_nxt = fe_value & afec_pkg::FE_CONFIG_WMASK;
				2'b10: prdata_nxt = pm_value;
				default: begin
					prdata_nxt = 32'h0000_0000;
					pslverr_nxt = 1'b1;
				end
			endcase
			if (req.pwrite) begin
				prdata_nxt = 32'h0000_0000;
			end
		end
	end

	// Read path registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (clk_en) begin
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = 1'b1; // Zero wait states
	assign pslverr = pslverr_r && req.psel && req.penable;

	// Enable outputs straight from the stored bits
	assign enables.dc_dac_buffer_on = fe_value[afec_pkg::DC_DAC_BUF_POS];
	assign enables.hs_dac_reference_on = fe_value[afec_pkg::HS_DAC_REF_POS];
	assign enables.regulator_current_limit_ctl = fe_value[afec_pkg::REG_ILIM_POS];
	assign enables.mains_reject_filter_on = fe_value[afec_pkg::MAINS_FILT_POS];
	assign enables.fourier_accel_on = fe_value[afec_pkg::FOURIER_POS];
	assign enables.low_enables = fe_value[afec_pkg::LOW_ENABLES_MSB:0];
	assign power_mode = pm_value;

	// Assertions
	property p_buf_follows_write;
		@(posedge pclk) disable iff (!presetn)
		wr_fe ##1 clk_en |-> enables.dc_dac_buffer_on == $past(pwdata[afec_pkg::DC_DAC_BUF_POS], 1);
	endproperty
	a_buf_follows_write: assert property (p_buf_follows_write) else $error("dc buffer wrong");

	property p_ref_follows_write;
		@(posedge pclk) disable iff (!presetn)
		wr_fe |=> enables.hs_dac_reference_on == $past(pwdata[afec_pkg::HS_DAC_REF_POS]);
	endproperty
	a_ref_follows_write: assert property (p_ref_follows_write) else $error("dac ref wrong");

	property p_ilim_write;
		@(posedge pclk) disable iff (!presetn)
		wr_fe |=> enables.regulator_current_limit_ctl == $past(pwdata[afec_pkg::REG_ILIM_POS]);
	endproperty
	a_ilim_write: assert property (p_ilim_write) else $error("current limit wrong");

	property p_filt_write;
		@(posedge pclk) disable iff (!presetn)
		wr_fe |=> enables.mains_reject_filter_on == $past(pwdata[afec_pkg::MAINS_FILT_POS]);
	endproperty
	a_filt_write: assert property (p_filt_write) else $error("filter enable wrong");

	property p_dft_write;
		@(posedge pclk) disable iff (!presetn)
		wr_fe |=> enables.fourier_accel_on == $past(pwdata[afec_pkg::FOURIER_POS]);
	endproperty
	a_dft_write: assert property (p_dft_write) else $error("fourier enable wrong");

	property p_fe_stable;
		@(posedge pclk) disable iff (!presetn)
		!wr_fe |=> $stable(fe_value);
	endproperty
	a_fe_stable: assert property (p_fe_stable) else $error("config changed unasked");

	property p_pm_read;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && paddr == afec_pkg::PM_CONFIG_ADDR && clk_en
			|=> prdata == $past(pm_value);
	endproperty
	a_pm_read: assert property (p_pm_read) else $error("power mode read wrong");

	// Power mode write lands whole
	property p_pm_write;
		@(posedge pclk) disable iff (!presetn)
		wr_pm |=> power_mode == $past(pwdata);
	endproperty
	a_pm_write: assert property (p_pm_write) else $error("power mode write lost");

	// Config read returns the stored bits
	property p_fe_read;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && paddr == afec_pkg::FE_CONFIG_ADDR && clk_en
			|=> prdata == $past(fe_value);
	endproperty
	a_fe_read: assert property (p_fe_read) else $error("config read wrong");

	// Both registers leave reset at their documented values
	property p_reset_values;
		@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> fe_value == afec_pkg::FE_CONFIG_RESET
			&& pm_value == afec_pkg::PM_CONFIG_RESET && enables.regulator_current_limit_ctl;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("reset value wrong");

	// Unmapped access answers with an error and zero data
	property p_unmapped_err;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && hit == 2'b00 && clk_en) ##1 (psel && penable)
			|-> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped not refused");

	// Write transfers read back zero
	property p_write_reads_zero;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && pwrite && clk_en |=> prdata == 32'h0000_0000;
	endproperty
	a_write_reads_zero: assert property (p_write_reads_zero) else $error("write gave read data");

	// Clock enable low freezes both config registers and the read data
	property p_freeze;
		@(posedge pclk) disable iff (!presetn)
		!clk_en |=> $stable(fe_value) && $stable(pm_value) && $stable(prdata);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");

	property p_reserved_zero;
		@(posedge pclk) disable iff (!presetn)
		fe_value[31:22] == 10'h000 && fe_value[18:17] == 2'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	// Main scenarios
	c_fe_write: cover property (@(posedge pclk) disable iff (!presetn) wr_fe);
	c_pm_write: cover property (@(posedge pclk) disable iff (!presetn) wr_pm);
	c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
	c_frozen: cover property (@(posedge pclk) disable iff (!presetn) !clk_en && psel && penable);
	c_ilim_on: cover property (@(posedge pclk) disable iff (!presetn)
		!enables.regulator_current_limit_ctl);

endmodule

// ---- rtl/afec_pkg.sv ----
// Package for the front end configuration register bank
package afec_pkg;

	// Byte addresses of the registers
	localparam logic [15:0] FE_CONFIG_ADDR = 16'h2000;
	localparam logic [15:0] PM_CONFIG_ADDR = 16'h22f0;

	// Values after reset
	localparam logic [31:0] FE_CONFIG_RESET = 32'h0008_0000;
	localparam logic [31:0] PM_CONFIG_RESET = 32'h0008_8800;

	// Field positions in the front end configuration register
	localparam int DC_DAC_BUF_POS = 21;
	localparam int HS_DAC_REF_POS = 20;
	localparam int REG_ILIM_POS = 19;
	localparam int MAINS_FILT_POS = 16;
	localparam int FOURIER_POS = 15;
	localparam int LOW_ENABLES_MSB = 14;

	// Writable bits of the front end configuration register
	localparam logic [31:0] FE_CONFIG_WMASK = 32'h0039_ffff;

	// Enable outputs gathered for the analog blocks
	typedef struct packed {
		logic dc_dac_buffer_on;
		logic hs_dac_reference_on;
		logic regulator_current_limit_ctl;
		logic mains_reject_filter_on;
		logic fourier_accel_on;
		logic [14:0] low_enables;
	} afec_enables_t;

	// APB request as seen by the slave
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [15:0] paddr;
		logic [31:0] pwdata;
	} afec_apb_req_t;

endpackage

// ---- rtl/afec_reg32.sv ----
// One 32-bit register with a reset value and a per-bit write mask
module afec_reg32 #(
	parameter logic [31:0] RESET_VAL = 32'h0000_0000,
	parameter logic [31:0] WMASK = 32'hffff_ffff
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Write port
	input wire logic wr_en,
	input wire logic [31:0] wr_data,
	// Stored value
	output logic [31:0] value
);

	logic [31:0] value_r;
	logic [31:0] value_nxt;

	// Next value: masked bits only, others keep reset value
	always_comb begin
		value_nxt = value_r;
		if (wr_en) begin
			value_nxt = (wr_data & WMASK) | (RESET_VAL & ~WMASK);
		end
	end

	// Storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_r <= RESET_VAL;
		end else if (clk_en) begin
			value_r <= value_nxt;
		end
	end

	assign value = value_r;

endmodule

// ---- tb/afec_top_test.sv ----
// Self-checking testbench for the front end configuration register bank
module afec_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	afec_pkg::afec_enables_t enables;
	logic [31:0] power_mode;
	logic [31:0] rd;
	logic err;
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;

	afec_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .enables(enables), .power_mode(power_mode));

	// Clock at 8 ns period
	always #4 pclk = ~pclk;

	// Hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		logic rdy;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			rdy = pready;
			rd = prdata;
			err = pslverr;
		end while (rdy !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Values after reset, seen on the bus and on the control outputs
	task automatic t_reset();
		apb(1'b0, afec_pkg::FE_CONFIG_ADDR, 32'h0);
		chk("config reset", 32'h0008_0000, rd);
		chk("enables reset", 32'h0002_0000, {12'h000, enables});
		chk("pready idle", 32'h1, {31'h0, pready});
		apb(1'b0, afec_pkg::PM_CONFIG_ADDR, 32'h0);
		chk("power reset", 32'h0008_8800, rd);
		chk("power out reset", 32'h0008_8800, power_mode);
	endtask

	// All ones then all zeros into the config register
	task automatic t_fields();
		apb(1'b1, afec_pkg::FE_CONFIG_ADDR, 32'hffff_ffff);
		chk("enables ones", 32'h000f_ffff, {12'h000, enables});
		apb(1'b0, afec_pkg::FE_CONFIG_ADDR, 32'h0);
		chk("reserved read zero", 32'h0039_ffff, rd);
		apb(1'b1, afec_pkg::FE_CONFIG_ADDR, 32'h0000_0000);
		chk("limit on", 32'h0, {31'h0, enables.regulator_current_limit_ctl});
		apb(1'b1, afec_pkg::FE_CONFIG_ADDR, 32'h0001_8000);
		chk("filter and fft", 32'h0001_8000, {12'h000, enables});
		apb(1'b0, afec_pkg::FE_CONFIG_ADDR, 32'h0);
		chk("config back", 32'h0001_8000, rd);
	endtask

	// Power mode register is fully writable
	task automatic t_power();
		apb(1'b1, afec_pkg::PM_CONFIG_ADDR, 32'ha5c3_0f96);
		chk("power out", 32'ha5c3_0f96, power_mode);
		apb(1'b0, afec_pkg::PM_CONFIG_ADDR, 32'h0);
		chk("power read", 32'ha5c3_0f96, rd);
	endtask

	// Unmapped address is refused and changes nothing
	task automatic t_unmapped();
		apb(1'b1, 16'h2004, 32'hffff_ffff);
		chk("unmapped write err", 32'h1, {31'h0, err});
		apb(1'b0, 16'h2004, 32'h0);
		chk("unmapped read err", 32'h1, {31'h0, err});
		chk("unmapped read data", 32'h0, rd);
		apb(1'b0, afec_pkg::FE_CONFIG_ADDR, 32'h0);
		chk("config kept", 32'h0001_8000, rd);
		chk("mapped no err", 32'h0, {31'h0, err});
	endtask

	// Clock enable low ignores writes, then the buffer bit alone
	task automatic t_freeze();
		clk_en <= 1'b0;
		apb(1'b1, afec_pkg::FE_CONFIG_ADDR, 32'h0020_0000);
		chk("frozen enables", 32'h0001_8000, {12'h000, enables});
		apb(1'b1, afec_pkg::PM_CONFIG_ADDR, 32'h0);
		chk("frozen power", 32'ha5c3_0f96, power_mode);
		clk_en <= 1'b1;
		apb(1'b1, afec_pkg::FE_CONFIG_ADDR, 32'h0020_0000);
		chk("buffer only", 32'h0008_0000, {12'h000, enables});
	endtask

	// Main sequence, with a second reset in mid-run
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_fields();
		t_power();
		t_unmapped();
		t_freeze();
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		print_verdict();
	end
endmodule
